// [core/tfcs_pkg.sv]
package tfcs_pkg;

  // Reference source codes for each transmit multiplier PLL and receive CDR
  localparam logic [2:0] REF_PIN_A      = 3'h0;
  localparam logic [2:0] REF_PIN_B      = 3'h1;
  localparam logic [2:0] REF_INTERBLOCK = 3'h2;
  localparam logic [2:0] REF_FABRIC_PIN = 3'h3;
  localparam logic [2:0] REF_LEFT_PLL   = 3'h4;
  localparam int         REF_W          = 3;

  // Reference routes, one-hot
  localparam logic [3:0] ROUTE_NONE      = 4'h0;
  localparam logic [3:0] ROUTE_LOCAL     = 4'h1;
  localparam logic [3:0] ROUTE_INTERBLK  = 4'h2;
  localparam logic [3:0] ROUTE_GLOBAL    = 4'h4;
  localparam logic [3:0] ROUTE_DEDICATED = 4'h8;
  localparam int         ROUTE_W         = 4;

  // Bonding modes
  localparam logic [1:0] BOND_NONE = 2'h0;
  localparam logic [1:0] BOND_X4   = 2'h1;
  localparam logic [1:0] BOND_X8   = 2'h2;
  localparam logic [1:0] BOND_BAD  = 2'h3;

  // Transmit FIFO write clock source, one-hot
  typedef enum logic [4:0] {
    TFCS_TXW_LOCAL  = 5'h01,
    TFCS_TXW_CH0    = 5'h02,
    TFCS_TXW_CH2    = 5'h04,
    TFCS_TXW_CORE   = 5'h08,
    TFCS_TXW_MASTER = 5'h10
  } tfcs_txw_t;
  localparam int TXW_W = 5;

  // Receive FIFO read clock source, one-hot
  typedef enum logic [1:0] {
    TFCS_RXR_RECOVERED = 2'h1,
    TFCS_RXR_TXSIDE    = 2'h2
  } tfcs_rxr_t;
  localparam int RXR_W = 2;

  // Configuration control states, one-hot
  typedef enum logic [2:0] {
    TFCS_ST_IDLE    = 3'h1,
    TFCS_ST_RUN     = 3'h2,
    TFCS_ST_PENDING = 3'h4
  } tfcs_state_t;

  // Reset values
  localparam logic [1:0] RST_BOND = BOND_NONE;

  // Route for one reference source code
  function automatic logic [3:0] tfcs_route_of(input logic [2:0] src);
    logic [3:0] r;
    r = ROUTE_NONE;
    case (src)
      REF_PIN_A:      r = ROUTE_LOCAL;
      REF_PIN_B:      r = ROUTE_LOCAL;
      REF_INTERBLOCK: r = ROUTE_INTERBLK;
      REF_FABRIC_PIN: r = ROUTE_GLOBAL;
      REF_LEFT_PLL:   r = ROUTE_DEDICATED;
      default:        r = ROUTE_NONE;
    endcase
    return r;
  endfunction : tfcs_route_of

endpackage : tfcs_pkg

// [core/tfcs_ref_route.sv]
`timescale 1ns/10ps
module tfcs_ref_route #(
  parameter int NUM_CH = 4
) (
  input  wire logic [NUM_CH*tfcs_pkg::REF_W-1:0]   i_src,    // Per-channel source codes
  output logic      [NUM_CH*tfcs_pkg::ROUTE_W-1:0] o_route,  // Per-channel one-hot routes
  output logic                                     o_valid   // All codes legal
);

  logic [NUM_CH-1:0] ok;

  // Map each source code to its network route
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      assign o_route[g*tfcs_pkg::ROUTE_W +: tfcs_pkg::ROUTE_W] =
        tfcs_pkg::tfcs_route_of(i_src[g*tfcs_pkg::REF_W +: tfcs_pkg::REF_W]);
      assign ok[g] = |o_route[g*tfcs_pkg::ROUTE_W +: tfcs_pkg::ROUTE_W];
    end
  endgenerate

  assign o_valid = &ok;

endmodule : tfcs_ref_route

// [core/tfcs_identity.sv]
`timescale 1ns/10ps
module tfcs_identity #(
  parameter int NUM_CH = 4,
  parameter int PLL_W  = 8,
  parameter int PCS_W  = 16
) (
  input  wire logic [NUM_CH*tfcs_pkg::REF_W-1:0] i_ref,      // Per-channel PLL reference source
  input  wire logic [NUM_CH*PLL_W-1:0]           i_pll,      // Per-channel PLL configuration
  input  wire logic [NUM_CH*PCS_W-1:0]           i_pcs,      // Per-channel PMA and PCS configuration
  output logic                                   o_all_same, // Every channel identical to channel 0
  output logic                                   o_pair_lo,  // Channels 0 and 1 identical
  output logic                                   o_pair_hi   // Channels 2 and 3 identical
);

  localparam int CFG_W = tfcs_pkg::REF_W + PLL_W + PCS_W;

  logic [CFG_W-1:0]  cfg [NUM_CH];
  logic [NUM_CH-1:0] same0;

  // Swing and pre-emphasis are not inputs, so they never break identity
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      assign cfg[g]   = {i_ref[g*tfcs_pkg::REF_W +: tfcs_pkg::REF_W],
                         i_pll[g*PLL_W +: PLL_W],
                         i_pcs[g*PCS_W +: PCS_W]};
      assign same0[g] = (cfg[g] == cfg[0]);
    end
  endgenerate

  assign o_all_same = &same0;
  assign o_pair_lo  = same0[1];
  assign o_pair_hi  = (cfg[2] == cfg[3]);

endmodule : tfcs_identity

// [core/tfcs_clock_select.sv]
`timescale 1ns/10ps
// Function
// - Forward per-channel parallel clock when non-bonded, bonded core clock when bonded.
// - Receive read clock is recovered clock, or transmit side clock with rate matcher.
// - Transmit FIFO write and read clocks share frequency exactly; only phase differs.
// - Each PLL and CDR picks a reference among four source kinds.
// - Fabric pin references use the global network; left PLL uses a dedicated path.
// - Channels identical when reference, PLL and PMA/PCS setup match; swing ignored.
// - Four identical non-bonded channels all write with channel 0 clock.
// - Otherwise identical pair 0/1 writes with channel 0 clock, identical pair 2/3 with channel 2 clock.
// - Four-channel bonding needs identical channels, all write with block core clock.
// - Eight-channel bonding writes every FIFO with the master block core clock.
module tfcs_clock_select #(
  parameter int NUM_CH = 4,
  parameter int PLL_W  = 8,
  parameter int PCS_W  = 16
) (
  input  wire logic                               i_clk,          // System clock, 50 MHz
  input  wire logic                               i_reset_n,      // Synchronous reset, active low
  input  wire logic                               i_cfg_load,     // Pulse: take new configuration
  input  wire logic                               i_fifo_busy,    // Phase compensation FIFOs moving data
  input  wire logic [1:0]                         i_bond_mode,    // None, four- or eight-channel
  input  wire logic                               i_rate_match,   // Rate matcher in receive path
  input  wire logic [NUM_CH*tfcs_pkg::REF_W-1:0]  i_pll_ref,      // Per-channel PLL reference source
  input  wire logic [NUM_CH*tfcs_pkg::REF_W-1:0]  i_cdr_ref,      // Per-channel CDR reference source
  input  wire logic [NUM_CH*PLL_W-1:0]            i_pll_cfg,      // Per-channel PLL configuration
  input  wire logic [NUM_CH*PCS_W-1:0]            i_pcs_cfg,      // Per-channel PMA and PCS setup
  output logic      [NUM_CH*tfcs_pkg::TXW_W-1:0]  o_tx_wr_sel,    // Per-channel FIFO write clock source
  output logic      [NUM_CH-1:0]                  o_tx_fwd_core,  // Forwarded clock is bonded core clock
  output logic      [NUM_CH*tfcs_pkg::RXR_W-1:0]  o_rx_rd_sel,    // Per-channel FIFO read clock source
  output logic      [NUM_CH*tfcs_pkg::ROUTE_W-1:0] o_pll_route,   // Per-channel PLL reference route
  output logic      [NUM_CH*tfcs_pkg::ROUTE_W-1:0] o_cdr_route,   // Per-channel CDR reference route
  output logic                                    o_all_identical, // Applied channels identical
  output logic                                    o_cfg_active,   // A load is applied or pending
  output logic                                    o_cfg_pending,  // Load waiting for FIFOs to idle
  output logic                                    o_cfg_error     // Applied setup is illegal
);

  // Held configuration: shadow takes a load, applied drives selection
  logic [1:0]                        sh_bond_r;
  logic                              sh_rm_r;
  logic [NUM_CH*tfcs_pkg::REF_W-1:0] sh_pll_ref_r;
  logic [NUM_CH*tfcs_pkg::REF_W-1:0] sh_cdr_ref_r;
  logic [NUM_CH*PLL_W-1:0]           sh_pll_cfg_r;
  logic [NUM_CH*PCS_W-1:0]           sh_pcs_cfg_r;
  logic [1:0]                        ap_bond_r;
  logic                              ap_rm_r;
  logic [NUM_CH*tfcs_pkg::REF_W-1:0] ap_pll_ref_r;
  logic [NUM_CH*tfcs_pkg::REF_W-1:0] ap_cdr_ref_r;
  logic [NUM_CH*PLL_W-1:0]           ap_pll_cfg_r;
  logic [NUM_CH*PCS_W-1:0]           ap_pcs_cfg_r;

  tfcs_pkg::tfcs_state_t state_r;
  tfcs_pkg::tfcs_state_t state_nxt;

  logic                                 apply_now;
  logic                                 apply_shadow;
  logic                                 take_shadow;
  logic                                 all_same;
  logic                                 pair_lo;
  logic                                 pair_hi;
  logic                                 pll_ok;
  logic                                 cdr_ok;
  logic                                 bonded;
  logic                                 bond_bad;
  logic                                 mode_bad;
  logic [NUM_CH*tfcs_pkg::TXW_W-1:0]    tx_wr_nxt;
  logic [NUM_CH-1:0]                    fwd_core_nxt;
  logic [NUM_CH*tfcs_pkg::RXR_W-1:0]    rx_rd_nxt;
  logic [NUM_CH*tfcs_pkg::ROUTE_W-1:0]  pll_route_nxt;
  logic [NUM_CH*tfcs_pkg::ROUTE_W-1:0]  cdr_route_nxt;
  logic                                 error_nxt;

  // Identity of the applied channel setups
  tfcs_identity #(
    .NUM_CH (NUM_CH),
    .PLL_W  (PLL_W),
    .PCS_W  (PCS_W)
  ) u_identity (
    .i_ref      (ap_pll_ref_r),
    .i_pll      (ap_pll_cfg_r),
    .i_pcs      (ap_pcs_cfg_r),
    .o_all_same (all_same),
    .o_pair_lo  (pair_lo),
    .o_pair_hi  (pair_hi)
  );

  // Reference routes for the transmit PLLs
  tfcs_ref_route #(
    .NUM_CH (NUM_CH)
  ) u_pll_route (
    .i_src   (ap_pll_ref_r),
    .o_route (pll_route_nxt),
    .o_valid (pll_ok)
  );

  // Reference routes for the receive CDRs
  tfcs_ref_route #(
    .NUM_CH (NUM_CH)
  ) u_cdr_route (
    .i_src   (ap_cdr_ref_r),
    .o_route (cdr_route_nxt),
    .o_valid (cdr_ok)
  );

  assign apply_now    = i_cfg_load && !i_fifo_busy;
  assign apply_shadow = (state_r == tfcs_pkg::TFCS_ST_PENDING) && !i_fifo_busy && !i_cfg_load;
  assign take_shadow  = i_cfg_load && i_fifo_busy;

  // Configuration control state sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      tfcs_pkg::TFCS_ST_IDLE: begin
        if (apply_now) begin
          state_nxt = tfcs_pkg::TFCS_ST_RUN;
        end else if (take_shadow) begin
          state_nxt = tfcs_pkg::TFCS_ST_PENDING;
        end
      end
      tfcs_pkg::TFCS_ST_RUN: begin
        if (take_shadow) begin
          state_nxt = tfcs_pkg::TFCS_ST_PENDING;
        end
      end
      tfcs_pkg::TFCS_ST_PENDING: begin
        if (apply_now || apply_shadow) begin
          state_nxt = tfcs_pkg::TFCS_ST_RUN;
        end
      end
      default: begin
        state_nxt = tfcs_pkg::TFCS_ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_r <= tfcs_pkg::TFCS_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Shadow copy of the mode flags of a load made while FIFOs are busy
  // Only the last load during a transfer is kept; earlier ones are dropped
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      sh_bond_r <= tfcs_pkg::RST_BOND;
      sh_rm_r   <= 1'b0;
    end else if (take_shadow) begin
      sh_bond_r <= i_bond_mode;
      sh_rm_r   <= i_rate_match;
    end
  end

  // Shadow copy of the channel setups of a load made while FIFOs are busy
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      sh_pll_ref_r <= '0;
      sh_cdr_ref_r <= '0;
      sh_pll_cfg_r <= '0;
      sh_pcs_cfg_r <= '0;
    end else if (take_shadow) begin
      sh_pll_ref_r <= i_pll_ref;
      sh_cdr_ref_r <= i_cdr_ref;
      sh_pll_cfg_r <= i_pll_cfg;
      sh_pcs_cfg_r <= i_pcs_cfg;
    end
  end

  // Applied mode changes only when idle
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ap_bond_r <= tfcs_pkg::RST_BOND;
      ap_rm_r   <= 1'b0;
    end else if (apply_now) begin
      ap_bond_r <= i_bond_mode;
      ap_rm_r   <= i_rate_match;
    end else if (apply_shadow) begin
      ap_bond_r <= sh_bond_r;
      ap_rm_r   <= sh_rm_r;
    end
  end

  // Applied setups change only when idle
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ap_pll_ref_r <= '0;
      ap_cdr_ref_r <= '0;
      ap_pll_cfg_r <= '0;
      ap_pcs_cfg_r <= '0;
    end else if (apply_now) begin
      ap_pll_ref_r <= i_pll_ref;
      ap_cdr_ref_r <= i_cdr_ref;
      ap_pll_cfg_r <= i_pll_cfg;
      ap_pcs_cfg_r <= i_pcs_cfg;
    end else if (apply_shadow) begin
      ap_pll_ref_r <= sh_pll_ref_r;
      ap_cdr_ref_r <= sh_cdr_ref_r;
      ap_pll_cfg_r <= sh_pll_cfg_r;
      ap_pcs_cfg_r <= sh_pcs_cfg_r;
    end
  end

  // Bonding decode and illegal setups
  assign bonded    = (ap_bond_r == tfcs_pkg::BOND_X4) || (ap_bond_r == tfcs_pkg::BOND_X8);
  assign bond_bad  = bonded && !all_same;
  // Mode code three names no bonding scheme
  assign mode_bad  = (ap_bond_r == tfcs_pkg::BOND_BAD);
  assign error_nxt = bond_bad || !pll_ok || !cdr_ok || mode_bad;

  // Per-channel clock source selection
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_sel
      tfcs_pkg::tfcs_txw_t txw;
      tfcs_pkg::tfcs_rxr_t rxr;
      logic                in_lo;

      assign in_lo = (g < 2);

      // Share a write clock between identical channels when non-bonded; bonded modes share the core clock regardless
      always_comb begin
        txw = tfcs_pkg::TFCS_TXW_LOCAL;
        case (ap_bond_r)
          tfcs_pkg::BOND_X4: txw = tfcs_pkg::TFCS_TXW_CORE;
          tfcs_pkg::BOND_X8: txw = tfcs_pkg::TFCS_TXW_MASTER;
          tfcs_pkg::BOND_NONE: begin
            if (all_same) begin
              txw = tfcs_pkg::TFCS_TXW_CH0;
            end else if (in_lo && pair_lo) begin
              txw = tfcs_pkg::TFCS_TXW_CH0;
            end else if (!in_lo && pair_hi) begin
              txw = tfcs_pkg::TFCS_TXW_CH2;
            end
          end
          default: txw = tfcs_pkg::TFCS_TXW_LOCAL;
        endcase
      end

      assign rxr = ap_rm_r ? tfcs_pkg::TFCS_RXR_TXSIDE : tfcs_pkg::TFCS_RXR_RECOVERED;

      assign tx_wr_nxt[g*tfcs_pkg::TXW_W +: tfcs_pkg::TXW_W] = txw;
      assign rx_rd_nxt[g*tfcs_pkg::RXR_W +: tfcs_pkg::RXR_W] = rxr;
      assign fwd_core_nxt[g] = bonded;
    end
  endgenerate

  // Registered selection outputs
  // All registered outputs lag the applied setup by one edge, so they change together
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_tx_wr_sel   <= {NUM_CH{tfcs_pkg::TFCS_TXW_LOCAL}};
      o_tx_fwd_core <= '0;
      o_rx_rd_sel   <= {NUM_CH{tfcs_pkg::TFCS_RXR_RECOVERED}};
    end else begin
      o_tx_wr_sel   <= tx_wr_nxt;
      o_tx_fwd_core <= fwd_core_nxt;
      o_rx_rd_sel   <= rx_rd_nxt;
    end
  end

  // Registered reference routes
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_pll_route <= '0;
      o_cdr_route <= '0;
    end else begin
      o_pll_route <= pll_route_nxt;
      o_cdr_route <= cdr_route_nxt;
    end
  end

  // Registered identity and error status
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_all_identical <= 1'b0;
      o_cfg_error     <= 1'b0;
    end else begin
      o_all_identical <= all_same;
      o_cfg_error     <= error_nxt && (state_r != tfcs_pkg::TFCS_ST_IDLE);
    end
  end

  // Status flags from the control state
  assign o_cfg_active  = (state_r != tfcs_pkg::TFCS_ST_IDLE);
  assign o_cfg_pending = (state_r == tfcs_pkg::TFCS_ST_PENDING);

endmodule : tfcs_clock_select

// [tb/tfcs_clock_select_assertions.sv]
`timescale 1ns/10ps
// Watches the clock select ports for selection, latency and hold rules
module tfcs_clock_select_assertions #(
  parameter int NUM_CH = 4,
  parameter int PLL_W  = 8,
  parameter int PCS_W  = 16
) (
  input wire logic                                 i_clk,           // System clock
  input wire logic                                 i_reset_n,       // Synchronous reset, active low
  input wire logic                                 i_cfg_load,      // Load pulse
  input wire logic                                 i_fifo_busy,     // FIFOs moving data
  input wire logic [1:0]                           i_bond_mode,     // Bonding mode
  input wire logic                                 i_rate_match,    // Rate matcher present
  input wire logic [NUM_CH*tfcs_pkg::REF_W-1:0]    i_pll_ref,       // PLL reference codes
  input wire logic [NUM_CH*tfcs_pkg::REF_W-1:0]    i_cdr_ref,       // CDR reference codes
  input wire logic [NUM_CH*tfcs_pkg::TXW_W-1:0]    o_tx_wr_sel,     // Write clock sources
  input wire logic [NUM_CH-1:0]                    o_tx_fwd_core,   // Core clock forwarded
  input wire logic [NUM_CH*tfcs_pkg::RXR_W-1:0]    o_rx_rd_sel,     // Read clock sources
  input wire logic [NUM_CH*tfcs_pkg::ROUTE_W-1:0]  o_pll_route,     // PLL routes
  input wire logic [NUM_CH*tfcs_pkg::ROUTE_W-1:0]  o_cdr_route,     // CDR routes
  input wire logic                                 o_all_identical, // Channels identical
  input wire logic                                 o_cfg_pending,   // Load deferred
  input wire logic                                 o_cfg_error      // Illegal setup
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // Forward flag agrees with the core write clock choice
  property p_fwd;
    o_tx_fwd_core[0] == (o_tx_wr_sel[4:0] == 5'h08 || o_tx_wr_sel[4:0] == 5'h10);
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward flag disagrees with write select");
  property p_rx;
    i_cfg_load && !i_fifo_busy ##1 !i_cfg_load [*2] |->
      ##1 o_rx_rd_sel == ($past(i_rate_match, 3) ? {NUM_CH{2'h2}} : {NUM_CH{2'h1}});
  endproperty
  a_rx: assert property (p_rx) else $error("read clock source wrong");
  property p_glb;
    i_cfg_load && !i_fifo_busy && i_pll_ref[2:0] == tfcs_pkg::REF_FABRIC_PIN ##1 !i_cfg_load [*2] |->
      ##1 o_pll_route[3:0] == tfcs_pkg::ROUTE_GLOBAL;
  endproperty
  a_glb: assert property (p_glb) else $error("fabric pin reference not global");
  property p_ded;
    i_cfg_load && !i_fifo_busy && i_cdr_ref[2:0] == tfcs_pkg::REF_LEFT_PLL ##1 !i_cfg_load [*2] |->
      ##1 o_cdr_route[3:0] == tfcs_pkg::ROUTE_DEDICATED;
  endproperty
  a_ded: assert property (p_ded) else $error("left PLL reference not dedicated");
  property p_ch0;
    o_all_identical && !(|o_tx_fwd_core) && !o_cfg_error |-> o_tx_wr_sel == {NUM_CH{5'h02}};
  endproperty
  a_ch0: assert property (p_ch0) else $error("identical channels not on channel 0");
  property p_x4;
    i_cfg_load && !i_fifo_busy && i_bond_mode == tfcs_pkg::BOND_X4 ##1 !i_cfg_load [*2] |->
      ##1 o_tx_wr_sel == {NUM_CH{5'h08}} && &o_tx_fwd_core;
  endproperty
  a_x4: assert property (p_x4) else $error("four-channel bond not on core clock");
  property p_x8;
    i_cfg_load && !i_fifo_busy && i_bond_mode == tfcs_pkg::BOND_X8 ##1 !i_cfg_load [*2] |->
      ##1 o_tx_wr_sel == {NUM_CH{5'h10}};
  endproperty
  a_x8: assert property (p_x8) else $error("eight-channel bond not on master clock");
  property p_pend;
    i_cfg_load && i_fifo_busy |=> o_cfg_pending;
  endproperty
  a_pend: assert property (p_pend) else $error("load during transfer not deferred");
  property p_hold;
    i_fifo_busy [*4] |-> $stable(o_tx_wr_sel) && $stable(o_pll_route) && $stable(o_rx_rd_sel);
  endproperty
  a_hold: assert property (p_hold) else $error("selection moved during transfer");
  c_x8: cover property (i_cfg_load && i_bond_mode == tfcs_pkg::BOND_X8);
  c_pend: cover property (o_cfg_pending);
  c_err: cover property (o_cfg_error);
endmodule : tfcs_clock_select_assertions

bind tfcs_clock_select tfcs_clock_select_assertions #(.NUM_CH(NUM_CH), .PLL_W(PLL_W), .PCS_W(PCS_W)) chk_u (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_cfg_load(i_cfg_load), .i_fifo_busy(i_fifo_busy),
  .i_bond_mode(i_bond_mode), .i_rate_match(i_rate_match), .i_pll_ref(i_pll_ref), .i_cdr_ref(i_cdr_ref),
  .o_tx_wr_sel(o_tx_wr_sel), .o_tx_fwd_core(o_tx_fwd_core), .o_rx_rd_sel(o_rx_rd_sel),
  .o_pll_route(o_pll_route), .o_cdr_route(o_cdr_route), .o_all_identical(o_all_identical),
  .o_cfg_pending(o_cfg_pending), .o_cfg_error(o_cfg_error));

// [tb/tfcs_fabric_model.sv]
`timescale 1ns/10ps
// Fabric side: runs transfer bursts and supplies the receiver detect clock
module tfcs_fabric_model (
  input  wire logic       i_clk,       // Fabric logic clock
  input  wire logic       i_reset_n,   // Synchronous reset, active low
  input  wire logic       i_go,        // Start a burst
  input  wire logic [7:0] i_len,       // Burst length in cycles
  output logic            o_busy,      // Transfer in progress
  output logic            o_fixed_clk  // Receiver detect clock
);
  logic [7:0] cnt_r;

  // burst logic on the same clock as the write port
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) cnt_r <= 8'h00;
    else if (i_go) cnt_r <= i_len;
    else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
  end
  assign o_busy = (cnt_r != 8'h00);

  initial o_fixed_clk = 1'b0;
  always #4 o_fixed_clk = ~o_fixed_clk;
endmodule : tfcs_fabric_model

// [tb/test_transceiver_fabric_clock_select.sv]
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module test_transceiver_fabric_clock_select;
  logic        i_clk = 1'b0, i_reset_n = 1'b0, i_cfg_load = 1'b0, i_rate_match = 1'b0, go = 1'b0;
  logic [1:0]  i_bond_mode = 2'h0;
  logic [11:0] i_pll_ref = '0, i_cdr_ref = '0;
  logic [31:0] i_pll_cfg = '0;
  logic [63:0] i_pcs_cfg = '0;
  logic        i_fifo_busy, fixed_clk, o_all_identical, o_cfg_active, o_cfg_pending, o_cfg_error;
  logic [19:0] o_tx_wr_sel;
  logic [3:0]  o_tx_fwd_core;
  logic [7:0]  o_rx_rd_sel;
  logic [15:0] o_pll_route, o_cdr_route;
  int          fail_count = 0, compares = 0;
  int          fixed_edges = 0;

  always #10 i_clk = ~i_clk;

  // Count rising edges of the fabric fixed clock
  always @(posedge fixed_clk) fixed_edges++;

  tfcs_fabric_model fab_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_go(go), .i_len(8'h0c),
    .o_busy(i_fifo_busy), .o_fixed_clk(fixed_clk));
  tfcs_clock_select dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cfg_load(i_cfg_load),
    .i_fifo_busy(i_fifo_busy), .i_bond_mode(i_bond_mode), .i_rate_match(i_rate_match),
    .i_pll_ref(i_pll_ref), .i_cdr_ref(i_cdr_ref), .i_pll_cfg(i_pll_cfg), .i_pcs_cfg(i_pcs_cfg),
    .o_tx_wr_sel(o_tx_wr_sel), .o_tx_fwd_core(o_tx_fwd_core), .o_rx_rd_sel(o_rx_rd_sel),
    .o_pll_route(o_pll_route), .o_cdr_route(o_cdr_route), .o_all_identical(o_all_identical),
    .o_cfg_active(o_cfg_active), .o_cfg_pending(o_cfg_pending), .o_cfg_error(o_cfg_error));

  task automatic finish_test();
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // One load pulse, then let the selection settle
  task automatic load(input logic [1:0] b, input logic rm);
    @(negedge i_clk);
    i_bond_mode  = b;
    i_rate_match = rm;
    i_cfg_load   = 1'b1;
    @(negedge i_clk);
    i_cfg_load = 1'b0;
    repeat (3) @(negedge i_clk);
  endtask : load

  // Loads during a transfer wait, the last one wins
  task automatic sc_busy();
    int n;
    @(negedge i_clk);
    go = 1'b1;
    @(negedge i_clk);
    go = 1'b0;
    i_bond_mode = tfcs_pkg::BOND_X4;
    i_cfg_load  = 1'b1;
    @(negedge i_clk);
    `CHK(o_cfg_pending, 1'b1)
    i_bond_mode = tfcs_pkg::BOND_X8;
    @(negedge i_clk);
    i_cfg_load = 1'b0;
    `CHK(o_tx_wr_sel, {4{5'h02}})
    for (n = 0; n < 40 && o_cfg_pending !== 1'b0; n++) @(negedge i_clk);
    if (n == 40) begin
      fail_count++;
      finish_test();
    end
    repeat (3) @(negedge i_clk);
    `CHK(o_tx_wr_sel, {4{5'h10}})
  endtask : sc_busy

  // Non-bonded grouping by identity
  task automatic sc_nonbond();
    i_pll_cfg = {4{8'h5a}};
    i_pcs_cfg = {4{16'h1234}};
    load(tfcs_pkg::BOND_NONE, 1'b0);
    `CHK(o_tx_wr_sel, {4{5'h02}})
    `CHK({o_tx_fwd_core, o_rx_rd_sel, o_all_identical, o_cfg_active}, {4'h0, 8'h55, 2'h3})
    i_pll_cfg[31:16] = {2{8'h33}};
    load(tfcs_pkg::BOND_NONE, 1'b0);
    `CHK({o_tx_wr_sel, o_all_identical}, {5'h04, 5'h04, 5'h02, 5'h02, 1'b0})
    i_pcs_cfg[31:16] = 16'h9999;
    load(tfcs_pkg::BOND_NONE, 1'b0);
    `CHK(o_tx_wr_sel, {5'h04, 5'h04, 5'h01, 5'h01})
    i_pll_ref[11:9] = 3'h1;
    load(tfcs_pkg::BOND_NONE, 1'b0);
    `CHK(o_tx_wr_sel, {4{5'h01}})
  endtask : sc_nonbond

  // Bonded modes and their faults
  task automatic sc_bond();
    i_pll_ref = '0;
    i_pll_cfg = {4{8'h5a}};
    i_pcs_cfg = {4{16'h1234}};
    load(tfcs_pkg::BOND_X4, 1'b1);
    `CHK({o_tx_wr_sel, o_tx_fwd_core, o_rx_rd_sel, o_cfg_error}, {{4{5'h08}}, 4'hf, 8'haa, 1'b0})
    load(tfcs_pkg::BOND_X8, 1'b0);
    `CHK({o_tx_wr_sel, o_tx_fwd_core, o_rx_rd_sel}, {{4{5'h10}}, 4'hf, 8'h55})
    load(2'h3, 1'b0);
    `CHK(o_cfg_error, 1'b1)
    i_pcs_cfg[63:48] = 16'h0bad;
    load(tfcs_pkg::BOND_X4, 1'b0);
    `CHK({o_tx_wr_sel, o_cfg_error}, {{4{5'h08}}, 1'b1})
  endtask : sc_bond

  // Every reference source and its route
  task automatic sc_routes();
    i_pll_ref = {3'h4, 3'h2, 3'h1, 3'h3};
    i_cdr_ref = {3'h0, 3'h3, 3'h2, 3'h4};
    load(tfcs_pkg::BOND_NONE, 1'b0);
    `CHK({o_pll_route, o_cdr_route, o_cfg_error}, {16'h8214, 16'h1428, 1'b0})
    i_pll_ref[2:0] = 3'h5;
    load(tfcs_pkg::BOND_NONE, 1'b0);
    `CHK({o_pll_route[3:0], o_cfg_error}, {4'h0, 1'b1})
  endtask : sc_routes

  // Fixed clock: ten rising edges in four system cycles, sampled off any edge
  task automatic sc_fixed();
    int e0;
    @(negedge i_clk);
    #1;
    e0 = fixed_edges;
    repeat (4) @(negedge i_clk);
    #1;
    `CHK(fixed_edges - e0, 10)
  endtask : sc_fixed

  initial begin
    repeat (12) @(negedge i_clk);
    i_reset_n = 1'b1;
    repeat (2) @(negedge i_clk);
    `CHK({o_tx_wr_sel, o_pll_route, o_cfg_active}, {{4{5'h02}}, 16'h1111, 1'b0})
    sc_busy();
    sc_nonbond();
    sc_bond();
    sc_routes();
    sc_fixed();
    finish_test();
  end
endmodule : test_transceiver_fabric_clock_select
